// ===== src/ctcr_regs.sv
// Cycle timing configuration register bank with an APB slave and a level interrupt.
// Assumes the APB master and the protocol engine share pclk; no input crosses a clock domain.
`timescale 1ns/10ps
module ctcr_regs
	import ctcr_pkg::*;
(
	// Clock and reset.
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave.
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	// Protocol engine side.
	input  wire ctcr_engine_s engine,
	output ctcr_cfg_s         cfg,
	output logic [W_UT_CYCLE-1:0] microticks_per_cycle,
	output logic              dyn_tx_start_ok,
	output logic              symbol_window_open,
	// Interrupt.
	output logic              irq
);

	// Register state.
	ctcr_cfg_s             cfg_reg;
	ctcr_cfg_s             cfg_next;
	logic [IRQ_W-1:0]      stat_reg;
	logic [IRQ_W-1:0]      stat_next;
	logic [IRQ_W-1:0]      mask_reg;
	logic [IRQ_W-1:0]      mask_next;
	logic [31:0]           rdata_reg;
	logic [31:0]           rdata_next;
	logic                  dyn_ok_reg;
	logic                  dyn_ok_next;
	logic                  sym_reg;
	logic                  sym_next;
	logic [W_UT_CYCLE-1:0] ut_reg;
	logic [W_UT_CYCLE-1:0] ut_next;

	// Decode helpers.
	logic [9:0]            idx;
	logic                  mapped;
	logic                  is_cfg;
	logic                  wr_acc;
	logic                  rd_setup;
	logic                  refused;
	logic [IRQ_W-1:0]      set_ev;
	logic                  cfg_wr_ok;
	logic                  full_wr;

	// Merge write data into an old value under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Read value of a register index; reserved bits come back as zero.
	function automatic logic [31:0] rd_val(input logic [9:0] i, input ctcr_cfg_s c,
		input logic [IRQ_W-1:0] st, input logic [IRQ_W-1:0] mk);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (i)
			IDX_SLOT_COUNT: r[W_SLOT_COUNT-1:0] = c.static_slot_count;
			IDX_STAT_PAY:   r[W_PAYLOAD-1:0]    = c.static_payload_words;
			IDX_DYN_PAY:    r[W_PAYLOAD-1:0]    = c.dynamic_payload_max_words;
			IDX_SLOT_MT:    r[W_SLOT_MT-1:0]    = c.static_slot_macroticks;
			IDX_CYC_LEN:    r[W_CTIME-1:0]      = c.cycle_length_macroticks;
			IDX_UT_LOW:     r[W_UT_LOW-1:0]     = c.cycle_microticks_low;
			IDX_UT_HIGH:    r[W_UT_HIGH-1:0]    = c.cycle_microticks_high;
			IDX_SYM_WIN:    r[W_CTIME-1:0]      = c.symbol_window_start;
			IDX_LATE_DYN:   r[W_CTIME-1:0]      = c.latest_dynamic_tx_start;
			IDX_MINI_MT:    r[W_MINI-1:0]       = c.minislot_macroticks;
			IDX_MINI_AP:    r[W_AP-1:0]         = c.minislot_action_offset;
			IDX_STAT_AP:    r[W_AP-1:0]         = c.static_action_offset;
			IDX_IRQ_STAT:   r[IRQ_W-1:0]        = st;
			IDX_IRQ_MASK:   r[IRQ_W-1:0]        = mk;
			default:        r = 32'h0000_0000;
		endcase
		return r;
	endfunction : rd_val

	// Address decode; misaligned or unknown addresses are unmapped.
	always_comb begin
		idx = paddr[11:2];
		is_cfg = 1'b0;
		unique case (idx)
			IDX_SLOT_COUNT, IDX_STAT_PAY, IDX_DYN_PAY, IDX_SLOT_MT, IDX_CYC_LEN,
			IDX_UT_LOW, IDX_UT_HIGH, IDX_SYM_WIN, IDX_LATE_DYN, IDX_MINI_MT,
			IDX_MINI_AP, IDX_STAT_AP: is_cfg = 1'b1;
			default: is_cfg = 1'b0;
		endcase
		mapped = (paddr[1:0] == 2'b00) &&
			(is_cfg || idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);
		wr_acc = psel && penable && pwrite && mapped;
		rd_setup = psel && !penable && !pwrite;
		refused = wr_acc && is_cfg && !engine.config_state; // RULE17
	end

	// The slave never stalls; a fresh answer is ready in every access phase.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Next values of the configuration, interrupt and engine-facing state.
	always_comb begin
		logic [31:0] m;
		m = 32'h0000_0000;
		cfg_next = cfg_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		if (wr_acc && is_cfg && engine.config_state) begin // RULE2
			m = merge(rd_val(idx, cfg_reg, stat_reg, mask_reg), pwdata, pstrb);
			// Only the defined field bits are stored, so reserved bits stay zero.
			unique case (idx)
				IDX_SLOT_COUNT: cfg_next.static_slot_count = m[W_SLOT_COUNT-1:0]; // RULE4
				IDX_STAT_PAY:   cfg_next.static_payload_words = m[W_PAYLOAD-1:0]; // RULE6
				IDX_DYN_PAY:    cfg_next.dynamic_payload_max_words = m[W_PAYLOAD-1:0]; // RULE11
				IDX_SLOT_MT:    cfg_next.static_slot_macroticks = m[W_SLOT_MT-1:0]; // RULE3
				IDX_CYC_LEN:    cfg_next.cycle_length_macroticks = m[W_CTIME-1:0]; // RULE14
				IDX_UT_LOW:     cfg_next.cycle_microticks_low = m[W_UT_LOW-1:0];
				IDX_UT_HIGH:    cfg_next.cycle_microticks_high = m[W_UT_HIGH-1:0]; // RULE1
				IDX_SYM_WIN:    cfg_next.symbol_window_start = m[W_CTIME-1:0]; // RULE13
				IDX_LATE_DYN:   cfg_next.latest_dynamic_tx_start = m[W_CTIME-1:0]; // RULE10
				IDX_MINI_MT:    cfg_next.minislot_macroticks = m[W_MINI-1:0]; // RULE7
				IDX_MINI_AP:    cfg_next.minislot_action_offset = m[W_AP-1:0]; // RULE8
				IDX_STAT_AP:    cfg_next.static_action_offset = m[W_AP-1:0]; // RULE9
				default:        cfg_next = cfg_reg;
			endcase
		end
		if (wr_acc && idx == IDX_IRQ_MASK && pstrb[0]) begin
			mask_next = pwdata[IRQ_W-1:0];
		end
		// Write-one-to-clear first, then new events, so a set in the same cycle wins.
		if (wr_acc && idx == IDX_IRQ_STAT && pstrb[0]) begin
			stat_next = stat_reg & ~pwdata[IRQ_W-1:0];
		end
		set_ev = '0;
		set_ev[IRQ_DPL_BIT] = engine.tx_len_valid &&
			(engine.tx_len > cfg_reg.dynamic_payload_max_words); // RULE12
		set_ev[IRQ_REFUSED_BIT] = refused;
		stat_next = stat_next | set_ev;
		// Read data is captured in the setup phase and stands through the access phase.
		rdata_next = rdata_reg;
		if (rd_setup) begin
			rdata_next = rd_val(idx, cfg_reg, stat_reg, mask_reg); // RULE16
		end
		// New dynamic transmissions are allowed only up to the latest start time.
		dyn_ok_next = (engine.cycle_time <= cfg_reg.latest_dynamic_tx_start); // RULE10
		sym_next = (engine.cycle_time >= cfg_reg.symbol_window_start); // RULE13
		ut_next = {cfg_reg.cycle_microticks_high, cfg_reg.cycle_microticks_low}; // RULE1
	end

	// State registers; timing fields with no defined reset start at zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '0;
			cfg_reg.static_slot_count <= RST_SLOT_COUNT;
			cfg_reg.static_payload_words <= RST_PAYLOAD;
			cfg_reg.dynamic_payload_max_words <= RST_PAYLOAD;
			stat_reg <= '0;
			mask_reg <= '0;
			rdata_reg <= 32'h0000_0000;
			dyn_ok_reg <= 1'b0;
			sym_reg <= 1'b0;
			ut_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			rdata_reg <= rdata_next;
			dyn_ok_reg <= dyn_ok_next;
			sym_reg <= sym_next;
			ut_reg <= ut_next;
		end
	end

	// Outputs other than pready and pslverr come straight from registers; irq is the OR of the status bits under the mask.
	assign cfg = cfg_reg;
	assign prdata = rdata_reg;
	assign dyn_tx_start_ok = dyn_ok_reg;
	assign symbol_window_open = sym_reg;
	assign microticks_per_cycle = ut_reg;
	assign irq = |(stat_reg & mask_reg);

	// A full-lane write to the slot length register in configuration state.
	sequence seq_cfg_write;
		psel && penable && pwrite && paddr == {IDX_SLOT_MT, 2'b00} &&
			pstrb == 4'hF && engine.config_state;
	endsequence

	// Any configuration write outside the configuration state.
	sequence seq_refused_write;
		psel && penable && pwrite && is_cfg && paddr[1:0] == 2'b00 && !engine.config_state;
	endsequence

	a_cfg_write_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		seq_cfg_write |=> cfg.static_slot_macroticks == $past(pwdata[W_SLOT_MT-1:0]))
		else $error("slot length write was not stored");

	a_refused_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
		seq_refused_write |=> $stable(cfg) && stat_reg[IRQ_REFUSED_BIT])
		else $error("write outside configuration state changed a register");

	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		psel && !penable && !pwrite && paddr == {IDX_SLOT_COUNT, 2'b00}
		|=> prdata[31:W_SLOT_COUNT] == '0)
		else $error("reserved slot count bits read nonzero");

	a_ut_combine: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		##1 microticks_per_cycle == $past({cfg.cycle_microticks_high, cfg.cycle_microticks_low}))
		else $error("microticks per cycle does not join both halves");

	a_dyn_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		engine.cycle_time > cfg.latest_dynamic_tx_start |=> !dyn_tx_start_ok)
		else $error("dynamic start allowed past the latest start time");

	a_sym_window: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		engine.cycle_time >= cfg.symbol_window_start |=> symbol_window_open)
		else $error("symbol window not open at its start time");

	a_dpl_err_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		engine.tx_len_valid && engine.tx_len > cfg.dynamic_payload_max_words
		|=> stat_reg[IRQ_DPL_BIT] ##0 (irq || !mask_reg[IRQ_DPL_BIT]))
		else $error("payload length error not flagged");

	a_no_write_outside: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		!engine.config_state |=> $stable(cfg) || $past(engine.config_state))
		else $error("configuration changed outside configuration state");

	a_slot_count_reset: assert property (@(posedge pclk) // RULE4
		!presetn |=> cfg.static_slot_count == RST_SLOT_COUNT || $past(wr_acc))
		else $error("slot count did not reset to one");

	// Accepted configuration writes, and those that carry all four byte lanes.
	assign cfg_wr_ok = wr_acc && is_cfg && engine.config_state;
	assign full_wr = cfg_wr_ok && pstrb == 4'hF;

	// Slot count: only its own accepted write moves it, and that write lands.
	a_count_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		!(cfg_wr_ok && idx == IDX_SLOT_COUNT) |=> $stable(cfg.static_slot_count))
		else $error("field changed without a write");

	a_count_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		full_wr && idx == IDX_SLOT_COUNT
		|=> cfg.static_slot_count == $past(pwdata[W_SLOT_COUNT-1:0]))
		else $error("field write was not stored");

	// Static payload limit.
	a_spay_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		!(cfg_wr_ok && idx == IDX_STAT_PAY) |=> $stable(cfg.static_payload_words))
		else $error("field changed without a write");

	a_spay_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		full_wr && idx == IDX_STAT_PAY
		|=> cfg.static_payload_words == $past(pwdata[W_PAYLOAD-1:0]))
		else $error("field write was not stored");

	// Dynamic payload limit.
	a_dpay_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		!(cfg_wr_ok && idx == IDX_DYN_PAY) |=> $stable(cfg.dynamic_payload_max_words))
		else $error("field changed without a write");

	a_dpay_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		full_wr && idx == IDX_DYN_PAY
		|=> cfg.dynamic_payload_max_words == $past(pwdata[W_PAYLOAD-1:0]))
		else $error("field write was not stored");

	// Slot length; its store is checked above.
	a_slot_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		!(cfg_wr_ok && idx == IDX_SLOT_MT) |=> $stable(cfg.static_slot_macroticks))
		else $error("field changed without a write");

	// Cycle length in macroticks.
	a_cyc_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		!(cfg_wr_ok && idx == IDX_CYC_LEN) |=> $stable(cfg.cycle_length_macroticks))
		else $error("field changed without a write");

	a_cyc_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		full_wr && idx == IDX_CYC_LEN
		|=> cfg.cycle_length_macroticks == $past(pwdata[W_CTIME-1:0]))
		else $error("field write was not stored");

	// Low half of the microticks per cycle.
	a_utlow_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		!(cfg_wr_ok && idx == IDX_UT_LOW) |=> $stable(cfg.cycle_microticks_low))
		else $error("field changed without a write");

	a_utlow_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		full_wr && idx == IDX_UT_LOW
		|=> cfg.cycle_microticks_low == $past(pwdata[W_UT_LOW-1:0]))
		else $error("field write was not stored");

	// High half of the microticks per cycle.
	a_uthigh_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		!(cfg_wr_ok && idx == IDX_UT_HIGH) |=> $stable(cfg.cycle_microticks_high))
		else $error("field changed without a write");

	a_uthigh_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		full_wr && idx == IDX_UT_HIGH
		|=> cfg.cycle_microticks_high == $past(pwdata[W_UT_HIGH-1:0]))
		else $error("field write was not stored");

	// Symbol window start.
	a_sym_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		!(cfg_wr_ok && idx == IDX_SYM_WIN) |=> $stable(cfg.symbol_window_start))
		else $error("field changed without a write");

	a_sym_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		full_wr && idx == IDX_SYM_WIN
		|=> cfg.symbol_window_start == $past(pwdata[W_CTIME-1:0]))
		else $error("field write was not stored");

	// Latest dynamic start time.
	a_late_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		!(cfg_wr_ok && idx == IDX_LATE_DYN) |=> $stable(cfg.latest_dynamic_tx_start))
		else $error("field changed without a write");

	a_late_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		full_wr && idx == IDX_LATE_DYN
		|=> cfg.latest_dynamic_tx_start == $past(pwdata[W_CTIME-1:0]))
		else $error("field write was not stored");

	// Minislot length.
	a_mini_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		!(cfg_wr_ok && idx == IDX_MINI_MT) |=> $stable(cfg.minislot_macroticks))
		else $error("field changed without a write");

	a_mini_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		full_wr && idx == IDX_MINI_MT
		|=> cfg.minislot_macroticks == $past(pwdata[W_MINI-1:0]))
		else $error("field write was not stored");

	// Minislot action point offset.
	a_miniap_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		!(cfg_wr_ok && idx == IDX_MINI_AP) |=> $stable(cfg.minislot_action_offset))
		else $error("field changed without a write");

	a_miniap_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		full_wr && idx == IDX_MINI_AP
		|=> cfg.minislot_action_offset == $past(pwdata[W_AP-1:0]))
		else $error("field write was not stored");

	// Static slot action point offset.
	a_statap_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		!(cfg_wr_ok && idx == IDX_STAT_AP) |=> $stable(cfg.static_action_offset))
		else $error("field changed without a write");

	a_statap_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		full_wr && idx == IDX_STAT_AP
		|=> cfg.static_action_offset == $past(pwdata[W_AP-1:0]))
		else $error("field write was not stored");

	// Up to the latest start time a new dynamic start stays allowed.
	a_dyn_open: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		engine.cycle_time <= cfg.latest_dynamic_tx_start |=> dyn_tx_start_ok)
		else $error("dynamic start blocked before the latest start time");

	// Before its start time the symbol window stays closed.
	a_sym_closed: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		engine.cycle_time < cfg.symbol_window_start |=> !symbol_window_open)
		else $error("symbol window open before its start time");

	// An unknown index reads as zero, but a misaligned read returns the word at its index.
	a_unmapped_rd: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		psel && !penable && !pwrite && !mapped |=> prdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");

	// The payload error stays set until software clears it with a one.
	a_dpl_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		stat_reg[IRQ_DPL_BIT] && !(wr_acc && idx == IDX_IRQ_STAT && pstrb[0])
		|=> stat_reg[IRQ_DPL_BIT])
		else $error("payload length error flag lost");

endmodule : ctcr_regs

// ===== pkg/ctcr_pkg.sv
// Constants, field layouts and carriers for the cycle timing configuration register bank.
// Assumes an APB master on pclk and a protocol engine on the same clock.
// Summary of operation
// RULE1: The microticks-per-cycle value joins the 8-bit high half in bits 7 to 0 above the low half.
// RULE2: Timing registers take host writes only in the configuration state, and the host writes only then.
// RULE3: The static slot length in macroticks is the 8-bit field in bits 7 to 0.
// RULE4: The static slot count is the 11-bit field in bits 10 to 0 and resets to one.
// RULE5: The host keeps the static slot count between 2 and 1023 so that two static slots exist.
// RULE6: The static payload limit in two-byte words is the 7-bit field in bits 6 to 0 and resets to zero.
// RULE7: The minislot length in macroticks is the 7-bit field in bits 6 to 0, kept by the host in 2 to 63.
// RULE8: The minislot action point offset is the 4-bit field in bits 3 to 0, kept by the host in 1 to 15.
// RULE9: The static slot action point offset is the 4-bit field in bits 3 to 0, kept in 1 to 15.
// RULE10: Past the 14-bit latest dynamic start time no new dynamic transmission begins.
// RULE11: The dynamic payload limit in two-byte words is the 7-bit field in bits 6 to 0 and resets to zero.
// RULE12: A transmit buffer length above the dynamic payload limit raises the payload length error flag.
// RULE13: The symbol window starts at the cycle time held in the 14-bit field in bits 13 to 0.
// RULE14: The macroticks per cycle come from the cycle length register.
// RULE15: The host sets nominal microticks per macrotick to cycle microticks divided by cycle macroticks.
// RULE16: Reserved bits read as zero and ignore writes.
// RULE17: A write outside the configuration state leaves the register contents unchanged.
package ctcr_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_SLOT_COUNT  = 10'h08E;
	localparam logic [9:0] IDX_STAT_PAY    = 10'h090;
	localparam logic [9:0] IDX_DYN_PAY     = 10'h092;
	localparam logic [9:0] IDX_SLOT_MT     = 10'h0B0;
	localparam logic [9:0] IDX_CYC_LEN     = 10'h0B2;
	localparam logic [9:0] IDX_UT_LOW      = 10'h0B4;
	localparam logic [9:0] IDX_UT_HIGH     = 10'h0B6;
	localparam logic [9:0] IDX_SYM_WIN     = 10'h0BC;
	localparam logic [9:0] IDX_LATE_DYN    = 10'h0C4;
	localparam logic [9:0] IDX_MINI_MT     = 10'h0C6;
	localparam logic [9:0] IDX_MINI_AP     = 10'h0C8;
	localparam logic [9:0] IDX_STAT_AP     = 10'h0CA;
	localparam logic [9:0] IDX_IRQ_STAT    = 10'h100;
	localparam logic [9:0] IDX_IRQ_MASK    = 10'h102;

	// Field widths, all starting at bit 0.
	localparam int W_SLOT_COUNT = 11;
	localparam int W_PAYLOAD    = 7;
	localparam int W_SLOT_MT    = 8;
	localparam int W_UT_HIGH    = 8;
	localparam int W_UT_LOW     = 16;
	localparam int W_CTIME      = 14;
	localparam int W_MINI       = 7;
	localparam int W_AP         = 4;
	localparam int W_UT_CYCLE   = W_UT_HIGH + W_UT_LOW;

	// Reset values.
	localparam logic [W_SLOT_COUNT-1:0] RST_SLOT_COUNT = 11'h001;
	localparam logic [W_PAYLOAD-1:0]    RST_PAYLOAD    = 7'h00;

	// Interrupt status and mask layout.
	localparam int IRQ_W           = 2;
	localparam int IRQ_DPL_BIT     = 0;
	localparam int IRQ_REFUSED_BIT = 1;

	// Configuration values handed to the protocol engine.
	typedef struct packed {
		logic [W_SLOT_COUNT-1:0] static_slot_count;
		logic [W_PAYLOAD-1:0]    static_payload_words;
		logic [W_PAYLOAD-1:0]    dynamic_payload_max_words;
		logic [W_SLOT_MT-1:0]    static_slot_macroticks;
		logic [W_CTIME-1:0]      cycle_length_macroticks;
		logic [W_UT_LOW-1:0]     cycle_microticks_low;
		logic [W_UT_HIGH-1:0]    cycle_microticks_high;
		logic [W_CTIME-1:0]      symbol_window_start;
		logic [W_CTIME-1:0]      latest_dynamic_tx_start;
		logic [W_MINI-1:0]       minislot_macroticks;
		logic [W_AP-1:0]         minislot_action_offset;
		logic [W_AP-1:0]         static_action_offset;
	} ctcr_cfg_s;

	// Cycle position and transmit buffer check from the protocol engine.
	typedef struct packed {
		logic                 config_state;
		logic [W_CTIME-1:0]   cycle_time;
		logic                 tx_len_valid;
		logic [W_PAYLOAD-1:0] tx_len;
	} ctcr_engine_s;

endpackage : ctcr_pkg

// ===== dv/ctcr_host.sv
// Host model: an APB master that runs one transfer per call.
// Assumes the slave answers on pclk and that pready may come late.
`timescale 1ns/10ps
module ctcr_host (
	// Clock.
	input  wire logic        pclk,
	// APB master side.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// Idle bus at time zero; whole words only, so every byte lane is on.
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		pstrb   = 4'hF;
	end

	// The request is held until pready is seen high or 50 cycles pass, so a slow slave is served too.
	task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err, output logic ok);
		ok = 1'b0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge pclk);
			ok = (pready === 1'b1);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : ctcr_host

// ===== dv/tb.sv
// Self-checking bench for the cycle timing register bank.
// Assumes the host model drives APB while the bench plays the protocol engine.
`timescale 1ns/10ps
module tb;
	import ctcr_pkg::*;
	logic                  pclk;
	logic                  presetn;
	logic                  psel, penable, pwrite, pready, pslverr;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic [3:0]            pstrb;
	ctcr_engine_s          eng;
	ctcr_cfg_s             cfg;
	logic [W_UT_CYCLE-1:0] upc;
	logic                  dok, swo, irq, se;
	int                    err_total, cmp_count;
	// Legal values keep the host ranges; reserved bits are set on purpose.
	logic [9:0]  r_idx [12] = '{IDX_SLOT_COUNT, IDX_STAT_PAY, IDX_DYN_PAY, IDX_SLOT_MT,
		IDX_CYC_LEN, IDX_UT_LOW, IDX_UT_HIGH, IDX_SYM_WIN, IDX_LATE_DYN, IDX_MINI_MT,
		IDX_MINI_AP, IDX_STAT_AP};
	logic [31:0] r_msk [12] = '{32'h7FF, 32'h7F, 32'h7F, 32'hFF, 32'h3FFF, 32'hFFFF,
		32'hFF, 32'h3FFF, 32'h3FFF, 32'h7F, 32'hF, 32'hF};
	logic [31:0] r_val [12] = '{32'h3FF, 32'h7F, 32'h55, 32'hA5, 32'h2D2A, 32'hC3E1,
		32'h96, 32'h1234, 32'h800, 32'h3F, 32'hF, 32'h1};

	ctcr_regs ctcr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .engine(eng), .cfg(cfg),
		.microticks_per_cycle(upc), .dyn_tx_start_ok(dok), .symbol_window_open(swo),
		.irq(irq));
	ctcr_host ctcr_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr));

	// Free-running 50 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask : chk1

	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// One bus transfer; a transfer that never completes ends the run.
	task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
		logic ok;
		ctcr_host_i.xfer(w, idx, d, rd, se, ok);
		if (ok !== 1'b1) begin
			err_total++;
			complete_run();
		end
	endtask : bus

	// One-cycle length check request from the engine side.
	task automatic pulse(input logic [6:0] len);
		@(posedge pclk);
		eng.tx_len_valid <= 1'b1;
		eng.tx_len       <= len;
		@(posedge pclk);
		eng.tx_len_valid <= 1'b0;
	endtask : pulse

	// Outputs follow the cycle time one cycle later, so two edges are allowed.
	task automatic ctime(input logic [13:0] t, input logic d, input logic s);
		@(posedge pclk);
		eng.cycle_time <= t;
		repeat (2) @(posedge pclk);
		#1;
		chk1(dok, d);
		chk1(swo, s);
	endtask : ctime

	// Hang guard: a run this long means a wait went wrong.
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		complete_run();
	end

	initial begin
		err_total = 0;
		cmp_count = 0;
		presetn = 1'b0;
		eng = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			bus(1'b0, r_idx[i], 32'h0);
			chk32(rd, (i == 0) ? 32'h1 : 32'h0);
		end
		$display("test reset_values done");
		eng.config_state <= 1'b1;
		for (int i = 0; i < 12; i++) bus(1'b1, r_idx[i], ~r_msk[i] | r_val[i]);
		for (int i = 0; i < 12; i++) begin
			bus(1'b0, r_idx[i], 32'h0);
			chk32(rd, r_val[i]);
		end
		chk32(32'(cfg.static_slot_count), 32'h3FF);
		chk32(32'(cfg.static_slot_macroticks), 32'hA5);
		chk32(32'(cfg.static_payload_words), 32'h7F);
		chk32(32'(cfg.dynamic_payload_max_words), 32'h55);
		chk32(32'(cfg.cycle_length_macroticks), 32'h2D2A);
		chk32(32'(cfg.minislot_macroticks), 32'h3F);
		chk32(32'(cfg.minislot_action_offset), 32'hF);
		chk32(32'(cfg.static_action_offset), 32'h1);
		chk32(32'(upc), 32'h96C3E1);
		$display("test config_writes done");
		eng.config_state <= 1'b0;
		bus(1'b1, IDX_SLOT_COUNT, 32'h2);
		bus(1'b0, IDX_SLOT_COUNT, 32'h0);
		chk32(rd, 32'h3FF);
		bus(1'b1, IDX_IRQ_MASK, 32'h3);
		bus(1'b0, IDX_IRQ_STAT, 32'h0);
		chk32(rd, 32'h2);
		chk1(irq, 1'b1);
		bus(1'b1, IDX_IRQ_STAT, 32'h2);
		bus(1'b0, IDX_IRQ_STAT, 32'h0);
		chk32(rd, 32'h0);
		chk1(irq, 1'b0);
		$display("test refused_write done");
		pulse(7'h55);
		bus(1'b0, IDX_IRQ_STAT, 32'h0);
		chk32(rd, 32'h0);
		pulse(7'h56);
		bus(1'b0, IDX_IRQ_STAT, 32'h0);
		chk32(rd, 32'h1);
		chk1(irq, 1'b1);
		bus(1'b1, IDX_IRQ_MASK, 32'h0);
		bus(1'b0, IDX_IRQ_STAT, 32'h0);
		chk1(irq, 1'b0);
		$display("test payload_check done");
		ctime(14'h0800, 1'b1, 1'b0);
		ctime(14'h0801, 1'b0, 1'b0);
		ctime(14'h1233, 1'b0, 1'b0);
		ctime(14'h1234, 1'b0, 1'b1);
		$display("test cycle_compare done");
		bus(1'b0, 10'h0A0, 32'h0);
		chk1(se, 1'b1);
		chk32(rd, 32'h0);
		$display("test unmapped done");
		complete_run();
	end
endmodule : tb
